// ### io_bus_module_select.v
// Host I/O bus decode, register select, sense, control and DMA handshake
//
// How it works
// - Low six bus lines carry device address; respond only on match.
// - Bus lines six to eight carry the three-bit function code.
// - Line eleven tags control function, line twelve tags sense test.
// - Line fourteen tags data transfer, line fifteen tags extended select.
// - Select codes zero to seven pick output registers one to eight.
// - Input enable and output strobe are chained to expansion modules.
// - Gated input word: line zero is LSB, line fifteen MSB.
// - Falling pacing-ready line, while connected, raises the DMA transfer request.
// - DMA word needs request raised, then acknowledge before moving.
// - Connect attaches module once DMA is armed or module select is high, connected shown, disconnect ends session.
// - DMA direction input decides whether word goes out or in.
// - Control output zero flags outward, one inward, in status only; both arm DMA.
// - Data-ready strobe loads or gates, and clears transfer latch.
// - Selection persists until another select code is issued or a system reset clears it.
// - Low sense line returns a true sense response.
`timescale 1ns/100ps
`include "io_bus_map.vh"
module io_bus_module_select #(
  parameter NREG = 8,
  parameter NIN  = 4
) (
  input  wire              clk_in,
  input  wire              rst_b_in,
  // Host bus
  input  wire [15:0]       host_bus_in,
  output reg  [15:0]       host_bus_out,
  output reg               host_bus_oe_out,
  input  wire              function_ready_strobe_in,
  input  wire              data_ready_strobe_in,
  input  wire              system_reset_in,
  output reg               sense_response_out,
  output reg               transfer_out_latch_out,
  // DMA controller
  input  wire              dma_connect_in,
  input  wire              dma_disconnect_in,
  input  wire              dma_transfer_ack_in,
  input  wire              dma_direction_in,
  input  wire              dma_module_select_in,
  output reg               dma_transfer_request_out,
  output reg               dma_connected_out,
  // External equipment
  input  wire              external_pacing_ready_b_in,
  input  wire [7:0]        sense_b_in,
  input  wire [7:0]        control_output_reset_b_in,
  output wire [7:0]        external_control_out,
  input  wire [16*NIN-1:0] gated_input_word_in,
  output reg  [NIN-1:0]    input_enable_chain_out,
  output reg  [NIN-1:0]    output_strobe_chain_out,
  output reg  [NREG-1:0]   register_load_pulse_out,
  output reg  [NREG-1:0]   register_select_line_out,
  output reg  [16*NREG-1:0] register_word_out,
  // Register port
  input  wire [1:0]        reg_addr_in,
  input  wire [15:0]       reg_wdata_in,
  input  wire              reg_wr_in,
  input  wire              reg_rd_in,
  output reg  [15:0]       reg_rdata_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Functions
  function [7:0] onehot8;
    input [2:0] code;
    begin
      onehot8 = 8'h01 << code;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [15:0] bus_s;
  wire [7:0]  ctl_s;
  wire [7:0]  sense_b_s;
  wire [7:0]  rex_b_s;
  wire        pace_b_s;

  sync2 #(.W(16), .RST_VAL(1'b0)) u_sync_bus (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (host_bus_in),
    .q_out    (bus_s)
  );

  sync2 #(.W(8), .RST_VAL(1'b0)) u_sync_ctl (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     ({function_ready_strobe_in, data_ready_strobe_in, system_reset_in,
                dma_connect_in, dma_disconnect_in, dma_transfer_ack_in,
                dma_direction_in, dma_module_select_in}),
    .q_out    (ctl_s)
  );

  sync2 #(.W(8), .RST_VAL(1'b1)) u_sync_sense (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (sense_b_in),
    .q_out    (sense_b_s)
  );

  sync2 #(.W(8), .RST_VAL(1'b1)) u_sync_rex (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (control_output_reset_b_in),
    .q_out    (rex_b_s)
  );

  sync2 #(.W(1), .RST_VAL(1'b1)) u_sync_pace (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (external_pacing_ready_b_in),
    .q_out    (pace_b_s)
  );

  wire fry_s  = ctl_s[7];
  wire dry_s  = ctl_s[6];
  wire srst_s = ctl_s[5];
  wire conn_s = ctl_s[4];
  wire disc_s = ctl_s[3];
  wire ack_s  = ctl_s[2];
  wire dir_s  = ctl_s[1];
  wire msel_s = ctl_s[0];

  //////////////////////////////////////////////////////////////////////////////
  // State
  reg  [5:0]  dev_addr_q;
  reg         enable_q;
  reg  [2:0]  sel_q;
  reg         sel_valid_q;
  reg         xfer_in_q;
  reg         armed_q;
  reg         dir_out_q;
  reg         fry_d_q;
  reg         dry_d_q;
  reg         ack_d_q;
  reg         pace_d_q;
  reg         gate_hold_q;

  wire        fry_rise  = fry_s & ~fry_d_q;
  wire        dry_rise  = dry_s & ~dry_d_q;
  wire        ack_rise  = ack_s & ~ack_d_q;
  wire        pace_fall = ~pace_b_s & pace_d_q;

  wire        addr_hit  = enable_q & (bus_s[`BUS_ADDR_MSB:0] == dev_addr_q);
  wire [2:0]  fcode     = bus_s[`BUS_FCODE_MSB:`BUS_FCODE_LSB];
  wire        func_ok   = fry_rise & addr_hit;
  wire        tag_exc   = bus_s[`BUS_TAG_EXC];
  wire        tag_sense = bus_s[`BUS_TAG_SENSE];
  wire        tag_data  = bus_s[`BUS_TAG_DATA];
  wire        tag_xsel  = bus_s[`BUS_TAG_XSEL];
  wire        no_tag    = ~(tag_exc | tag_sense | tag_data | tag_xsel);

  wire [7:0]  exc_set   = (func_ok & tag_exc) ? onehot8(fcode) : 8'h00;

  // Program transfers on the data strobe, DMA transfers on the acknowledge
  wire        dma_move  = ack_rise & dma_connected_out & dma_transfer_request_out;
  wire        load_ev   = sel_valid_q & ((dry_rise & transfer_out_latch_out)
                                         | (dma_move & dir_s));
  wire        gate_ev   = sel_valid_q & ((dry_rise & xfer_in_q)
                                         | (dma_move & ~dir_s));
  wire [1:0]  mod_idx   = sel_q[2:1];

  //////////////////////////////////////////////////////////////////////////////
  // Control outputs
  control_output_bank #(.N(8)) u_ctl_bank (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .set_in   (exc_set),
    .clr_b_in (rex_b_s),
    .ctl_out  (external_control_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Select, transfer latch and DMA handshake
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      fry_d_q                  <= 1'b0;
      dry_d_q                  <= 1'b0;
      ack_d_q                  <= 1'b0;
      pace_d_q                 <= 1'b1;
      sel_q                    <= 3'h0;
      sel_valid_q              <= 1'b0;
      transfer_out_latch_out   <= 1'b0;
      xfer_in_q                <= 1'b0;
      armed_q                  <= 1'b0;
      dir_out_q                <= 1'b0;
      dma_connected_out        <= 1'b0;
      dma_transfer_request_out <= 1'b0;
    end
    else
    begin
      fry_d_q  <= fry_s;
      dry_d_q  <= dry_s;
      ack_d_q  <= ack_s;
      pace_d_q <= pace_b_s;
      if (srst_s)
      begin
        sel_q                    <= 3'h0;
        sel_valid_q              <= 1'b0;
        transfer_out_latch_out   <= 1'b0;
        xfer_in_q                <= 1'b0;
        armed_q                  <= 1'b0;
        dir_out_q                <= 1'b0;
        dma_connected_out        <= 1'b0;
        dma_transfer_request_out <= 1'b0;
      end
      else
      begin
        // Strobe clears first so that a fresh function instruction wins
        if (dry_rise)
        begin
          transfer_out_latch_out <= 1'b0;
          xfer_in_q              <= 1'b0;
        end
        if (func_ok & tag_xsel)
        begin
          sel_q       <= fcode;
          sel_valid_q <= 1'b1;
        end
        if (func_ok & tag_data)
          transfer_out_latch_out <= 1'b1;
        else if (func_ok & no_tag)
          xfer_in_q <= 1'b1;
        if (disc_s)
        begin
          dma_connected_out        <= 1'b0;
          dma_transfer_request_out <= 1'b0;
          armed_q                  <= 1'b0;
        end
        else
        begin
          if (conn_s & (armed_q | msel_s))
            dma_connected_out <= 1'b1;
          if (ack_rise)
            dma_transfer_request_out <= 1'b0;
          if (pace_fall & dma_connected_out)
            dma_transfer_request_out <= 1'b1;
        end
        // Control outputs zero and one set the status direction flag and arm DMA; arming beats disconnect
        if (exc_set[0] | exc_set[1])
        begin
          armed_q   <= 1'b1;
          dir_out_q <= exc_set[0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output registers, gated inputs and chains
  integer i;

  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      register_word_out        <= {16*NREG{1'b0}};
      register_load_pulse_out  <= {NREG{1'b0}};
      register_select_line_out <= {NREG{1'b0}};
      output_strobe_chain_out  <= {NIN{1'b0}};
      input_enable_chain_out   <= {NIN{1'b0}};
      host_bus_out             <= 16'h0000;
      host_bus_oe_out          <= 1'b0;
      gate_hold_q              <= 1'b0;
      sense_response_out       <= 1'b0;
    end
    else
    begin
      register_select_line_out <= sel_valid_q ? onehot8(sel_q) : 8'h00;
      register_load_pulse_out  <= load_ev ? onehot8(sel_q) : 8'h00;
      for (i = 0; i < NIN; i = i + 1)
        output_strobe_chain_out[i] <= load_ev & (mod_idx == i);
      for (i = 0; i < NREG; i = i + 1)
        if (load_ev & (sel_q == i))
          register_word_out[16*i +: 16] <= bus_s;
      // Input word held on the bus until both the strobe and acknowledge are low
      if (gate_ev)
      begin
        gate_hold_q     <= 1'b1;
        host_bus_out    <= gated_input_word_in[16*mod_idx +: 16];
        host_bus_oe_out <= 1'b1;
        for (i = 0; i < NIN; i = i + 1)
          input_enable_chain_out[i] <= (mod_idx == i);
      end
      else if (gate_hold_q & ~dry_s & ~ack_s)
      begin
        gate_hold_q            <= 1'b0;
        host_bus_oe_out        <= 1'b0;
        input_enable_chain_out <= {NIN{1'b0}};
      end
      // Sense answer stands while the function strobe is held
      sense_response_out <= fry_s & addr_hit & tag_sense & ~sense_b_s[fcode];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register port
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      dev_addr_q    <= `RST_DEV_ADDR;
      enable_q      <= `RST_ENABLE;
      reg_rdata_out <= 16'h0000;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == `REG_CONFIG)
      begin
        dev_addr_q <= reg_wdata_in[`CFG_ADDR_MSB:0];
        enable_q   <= reg_wdata_in[`CFG_ENABLE];
      end
      reg_rdata_out <= 16'h0000;
      if (reg_rd_in)
      begin
        if (reg_addr_in == `REG_CONFIG)
          reg_rdata_out <= {9'h000, enable_q, dev_addr_q};
        else if (reg_addr_in == `REG_STATUS)
          reg_rdata_out <= {6'h00, dir_out_q, dma_transfer_request_out,
                            dma_connected_out, armed_q, xfer_in_q,
                            transfer_out_latch_out, sel_valid_q, sel_q};
      end
    end
  end

endmodule // io_bus_module_select

// ### io_bus_map.vh
// Constants for the host I/O bus select block: bus fields, register offsets, reset values
`ifndef IO_BUS_MAP_VH
`define IO_BUS_MAP_VH

// Host bus fields
`define BUS_ADDR_MSB      5
`define BUS_FCODE_LSB     6
`define BUS_FCODE_MSB     8
`define BUS_TAG_EXC       11
`define BUS_TAG_SENSE     12
`define BUS_TAG_DATA      14
`define BUS_TAG_XSEL      15

// Register port offsets
`define REG_CONFIG        2'h0
`define REG_STATUS        2'h1

// Config register fields
`define CFG_ADDR_MSB      5
`define CFG_ENABLE        6

// Status register fields
`define ST_SEL_LSB        0
`define ST_SEL_MSB        2
`define ST_SEL_VALID      3
`define ST_XFER_OUT       4
`define ST_XFER_IN        5
`define ST_DMA_ARMED      6
`define ST_DMA_CONN       7
`define ST_DMA_REQ        8
`define ST_DMA_DIR_OUT    9

// Reset values
`define RST_DEV_ADDR      6'h28
`define RST_ENABLE        1'h1

`endif

// ### sync2.v
// Two-flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sync2 #(
  parameter W       = 1,
  parameter RST_VAL = 1'b0
) (
  input  wire         clk_in,
  input  wire         rst_b_in,
  input  wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_q <= {W{RST_VAL}};
      sync_q <= {W{RST_VAL}};
    end
    else
    begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule // sync2

// ### control_output_bank.v
// Eight set/reset external-control output flip-flops
`timescale 1ns/100ps
module control_output_bank #(
  parameter N = 8
) (
  input  wire         clk_in,
  input  wire         rst_b_in,
  input  wire [N-1:0] set_in,
  input  wire [N-1:0] clr_b_in,
  output reg  [N-1:0] ctl_out
);

  // Output stays set until its own reset input is driven low; a set wins
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ctl_out <= {N{1'b0}};
    else
      ctl_out <= (ctl_out & clr_b_in) | set_in;
  end

endmodule // control_output_bank

// ### io_bus_checker.sv
// Port assertions for the host bus select block
`timescale 1ns/100ps
module io_bus_checker #(
  parameter NREG = 8,
  parameter NIN  = 4
) (
  input wire            clk_in,
  input wire            rst_b_in,
  input wire            system_reset_in,
  input wire            function_ready_strobe_in,
  input wire            dma_connect_in,
  input wire [7:0]      control_output_reset_b_in,
  input wire            sense_response_out,
  input wire            transfer_out_latch_out,
  input wire            dma_transfer_request_out,
  input wire            dma_connected_out,
  input wire            host_bus_oe_out,
  input wire [7:0]      external_control_out,
  input wire [NIN-1:0]  input_enable_chain_out,
  input wire [NIN-1:0]  output_strobe_chain_out,
  input wire [NREG-1:0] register_load_pulse_out,
  input wire [NREG-1:0] register_select_line_out
);
  wire [7:0] lp = register_load_pulse_out;
  wire [7:0] rb = control_output_reset_b_in;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_sys_reset;
    system_reset_in [*6];
  endsequence
  sequence s_load;
    |lp;
  endsequence
  a_load_single: assert property (s_load |=> lp == 8'h00)
    else $error("load pulse longer than one cycle");
  a_load_in_sel: assert property (s_load |-> $onehot(lp) && (lp & ~register_select_line_out) == 8'h00)
    else $error("load pulse outside current select");
  a_chain_pairs: assert property (output_strobe_chain_out == {|lp[7:6], |lp[5:4], |lp[3:2], |lp[1:0]})
    else $error("strobe chain does not follow loaded pair");
  a_sel_onehot: assert property ($onehot0(register_select_line_out))
    else $error("more than one select line");
  a_oe_input: assert property (host_bus_oe_out |-> $onehot(input_enable_chain_out))
    else $error("bus driven without one input enable");
  a_reset_clears: assert property (s_sys_reset |-> register_select_line_out == 8'h00 && !transfer_out_latch_out && !dma_connected_out && !dma_transfer_request_out)
    else $error("system reset left state behind");
  a_conn_cause: assert property ($rose(dma_connected_out) |-> $past(dma_connect_in, 2) || $past(dma_connect_in, 3) || $past(dma_connect_in, 4))
    else $error("connected without connect");
  a_req_conn: assert property ($rose(dma_transfer_request_out) |-> dma_connected_out)
    else $error("request while not connected");
  a_sense_strobe: assert property (sense_response_out |-> $past(function_ready_strobe_in, 3) || $past(function_ready_strobe_in, 4) || $past(function_ready_strobe_in, 5))
    else $error("sense response without function strobe");
  a_ctl_hold: assert property ((~external_control_out & $past(external_control_out) & $past(rb) & $past(rb, 2) & $past(rb, 3) & $past(rb, 4)) == 8'h00)
    else $error("control output dropped without its reset");
endmodule // io_bus_checker

bind io_bus_module_select io_bus_checker #(.NREG(NREG), .NIN(NIN)) u_chk (
  .clk_in, .rst_b_in, .system_reset_in, .function_ready_strobe_in, .dma_connect_in,
  .control_output_reset_b_in, .sense_response_out, .transfer_out_latch_out,
  .dma_transfer_request_out, .dma_connected_out, .host_bus_oe_out, .external_control_out,
  .input_enable_chain_out, .output_strobe_chain_out, .register_load_pulse_out,
  .register_select_line_out);

// ### dma_partner.sv
// Channel controller and pacing source on the far side of the block
`timescale 1ns/100ps
module dma_partner (
  input  wire clk_in,
  input  wire start_in,
  input  wire slow_in,
  input  wire request_in,
  input  wire connected_in,
  output reg  connect_out,
  output reg  disconnect_out,
  output reg  ack_out,
  output reg  pacing_b_out,
  output reg  done_out,
  output reg  fault_out
);
  integer n;
  initial
  begin
    connect_out = 1'b0;
    disconnect_out = 1'b0;
    ack_out = 1'b0;
    pacing_b_out = 1'b1;
    done_out = 1'b0;
    fault_out = 1'b0;
  end
  // One session: connect, one paced word, acknowledge, disconnect
  always
  begin
    @(posedge clk_in);
    if (start_in)
    begin
      done_out <= 1'b0;
      connect_out <= 1'b1;
      @(posedge clk_in);
      for (n = 0; n < 20 && !connected_in; n = n + 1) @(posedge clk_in);
      connect_out <= 1'b0;
      if (!connected_in) fault_out <= 1'b1;
      // Short low pulse, far below the allowed width
      pacing_b_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      pacing_b_out <= 1'b1;
      for (n = 0; n < 20 && !request_in; n = n + 1) @(posedge clk_in);
      if (!request_in) fault_out <= 1'b1;
      repeat (slow_in ? 30 : 1) @(posedge clk_in);
      ack_out <= 1'b1;
      for (n = 0; n < 20 && request_in; n = n + 1) @(posedge clk_in);
      ack_out <= 1'b0;
      if (request_in) fault_out <= 1'b1;
      disconnect_out <= 1'b1;
      @(posedge clk_in);
      for (n = 0; n < 20 && connected_in; n = n + 1) @(posedge clk_in);
      disconnect_out <= 1'b0;
      if (connected_in) fault_out <= 1'b1;
      done_out <= 1'b1;
    end
  end
endmodule // dma_partner

// ### tb.sv
// Self-checking bench for the host bus select block
`timescale 1ns/100ps
`include "io_bus_map.vh"
module tb;
  reg          clk_in, rst_b_in, fstb, dstb, sys_rst, dir, start, slow, rwr, rrd, sr, oe;
  reg  [15:0]  bus_in, rnd, rwd, hb, w;
  reg  [7:0]   sense_b, rex_b, lp;
  reg  [63:0]  gated;
  reg  [5:0]   dev;
  reg  [3:0]   sc, ie;
  reg  [1:0]   ra;
  integer      errors, samples_checked, k, j, i;
  wire [15:0]  hbo, rdo;
  wire [127:0] rwo;
  wire [7:0]   exo, selo, lpo;
  wire [3:0]   iec, osc;
  wire         oeo, sro, lat, req, con, dcon, ddis, dack, pace_b, pdone, pfault;
  io_bus_module_select u_io_bus_module_select (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .host_bus_in(bus_in), .host_bus_out(hbo),
    .host_bus_oe_out(oeo), .function_ready_strobe_in(fstb), .data_ready_strobe_in(dstb),
    .system_reset_in(sys_rst), .sense_response_out(sro), .transfer_out_latch_out(lat),
    .dma_connect_in(dcon), .dma_disconnect_in(ddis), .dma_transfer_ack_in(dack),
    .dma_direction_in(dir), .dma_module_select_in(1'b0),
    .dma_transfer_request_out(req), .dma_connected_out(con),
    .external_pacing_ready_b_in(pace_b), .sense_b_in(sense_b),
    .control_output_reset_b_in(rex_b), .external_control_out(exo),
    .gated_input_word_in(gated), .input_enable_chain_out(iec), .output_strobe_chain_out(osc),
    .register_load_pulse_out(lpo), .register_select_line_out(selo), .register_word_out(rwo),
    .reg_addr_in(ra), .reg_wdata_in(rwd), .reg_wr_in(rwr), .reg_rd_in(rrd),
    .reg_rdata_out(rdo));
  dma_partner u_dma_partner (
    .clk_in(clk_in), .start_in(start), .slow_in(slow), .request_in(req), .connected_in(con),
    .connect_out(dcon), .disconnect_out(ddis), .ack_out(dack), .pacing_b_out(pace_b),
    .done_out(pdone), .fault_out(pfault));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [15:0] fword(input [15:0] tags, input [2:0] code, input [5:0] a);
    fword = tags | {7'h00, code, a};
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  // Host strobe cycle; snapshots outputs while the strobe is held
  task strobe(input [15:0] word, input is_data);
    @(posedge clk_in);
    bus_in <= word;
    cyc(4);
    if (is_data) dstb <= 1'b1;
    else fstb <= 1'b1;
    lp = 8'h00;
    for (i = 0; i < 6; i = i + 1)
    begin
      @(negedge clk_in);
      if (lpo !== 8'h00)
      begin
        lp = lpo;
        sc = osc;
      end
      if (i == 4)
      begin
        sr = sro;
        oe = oeo;
        hb = hbo;
        ie = iec;
      end
    end
    @(posedge clk_in);
    dstb <= 1'b0;
    fstb <= 1'b0;
    cyc(5);
  endtask
  task rw(input [1:0] a, input [15:0] d);
    @(posedge clk_in);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk_in);
    rwr <= 1'b0;
  endtask
  task rr(input [1:0] a, output [15:0] d);
    @(posedge clk_in);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk_in);
    rrd <= 1'b0;
    @(negedge clk_in);
    d = rdo;
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial
  begin
    repeat (60000) @(posedge clk_in);
    errors = errors + 1;
    final_report;
  end
  initial
  begin
    errors = 0;
    samples_checked = 0;
    {rst_b_in, fstb, dstb, sys_rst, dir, start, slow, rwr, rrd} = 9'h000;
    {bus_in, rwd, ra} = 34'h0;
    sense_b = 8'hff;
    rex_b = 8'hff;
    rnd = 16'h0037;
    for (k = 0; k < 4; k = k + 1)
    begin
      rnd = lfsr(rnd);
      gated[16*k +: 16] = rnd;
    end
    cyc(16);
    rst_b_in <= 1'b1;
    cyc(4);
    rr(2'h0, w);
    chk(w, {9'h000, `RST_ENABLE, `RST_DEV_ADDR});
    rw(2'h1, 16'hffff);
    rr(2'h1, w);
    chk(w, 16'h0000);
    rr(2'h3, w);
    chk(w, 16'h0000);
    dev = 6'h15;
    rw(2'h0, {9'h000, 1'b0, dev});
    strobe(fword(16'h8000, 3'h3, dev), 1'b0);
    chk({8'h00, selo}, 16'h0000);
    rw(2'h0, {9'h000, 1'b1, dev});
    rr(2'h0, w);
    chk(w, 16'h0055);
    strobe(fword(16'h8000, 3'h3, `RST_DEV_ADDR), 1'b0);
    chk({8'h00, selo}, 16'h0000);
    for (k = 0; k < 8; k = k + 1)
    begin
      strobe(fword(16'h8000, k, dev), 1'b0);
      chk({8'h00, selo}, 1 << k);
      for (j = 0; j < 2; j = j + 1)
      begin
        strobe(fword(16'h4000, 3'h0, dev), 1'b0);
        chk({15'h0, lat}, 16'h0001);
        rnd = lfsr(rnd);
        strobe(rnd, 1'b1);
        chk({8'h00, lp}, 1 << k);
        chk({12'h000, sc}, 1 << (k / 2));
        chk(rwo[16*k +: 16], rnd);
        chk({15'h0, lat}, 16'h0000);
      end
      strobe(fword(16'h0000, 3'h0, dev), 1'b0);
      strobe(16'h0000, 1'b1);
      chk({15'h0, oe}, 16'h0001);
      chk(hb, gated[16*(k/2) +: 16]);
      chk({12'h000, ie}, 1 << (k / 2));
    end
    for (k = 0; k < 8; k = k + 1)
    begin
      rnd = lfsr(rnd);
      sense_b <= rnd[7:0];
      strobe(fword(16'h1000, k, dev), 1'b0);
      chk({15'h0, sr}, {15'h0, !rnd[k]});
      strobe(fword(16'h0800, k, dev), 1'b0);
      chk({8'h00, exo}, 1 << k);
      rex_b <= ~(8'h01 << k);
      cyc(5);
      rex_b <= 8'hff;
      cyc(3);
      chk({8'h00, exo}, 16'h0000);
    end
    strobe(fword(16'h0800, 3'h2, dev), 1'b0);
    strobe(fword(16'h0800, 3'h3, dev), 1'b0);
    rex_b <= {1'b1, ~exo[7], 1'b1, ~exo[5], 1'b1, ~exo[3], 1'b1, ~exo[1]};
    cyc(5);
    chk({8'h00, exo}, 16'h0008);
    rex_b <= 8'hff;
    for (j = 0; j < 2; j = j + 1)
    begin
      strobe(fword(16'h0800, j, dev), 1'b0);
      w = rwo[127:112];
      rnd = lfsr(rnd);
      bus_in <= rnd;
      gated[63:48] <= ~rnd;
      dir <= (j == 0);
      slow <= j;
      start <= 1'b1;
      @(posedge clk_in);
      start <= 1'b0;
      cyc(2);
      for (i = 0; i < 400 && !pdone; i = i + 1) @(posedge clk_in);
      if (!pdone)
      begin
        errors = errors + 1;
        final_report;
      end
      chk({15'h0, pfault}, 16'h0000);
      chk({14'h0, con, req}, 16'h0000);
      chk(rwo[127:112], (j == 0) ? rnd : w);
      if (j == 1) chk(hbo, ~rnd);
    end
    strobe(fword(16'h4000, 3'h0, dev), 1'b0);
    sys_rst <= 1'b1;
    cyc(8);
    sys_rst <= 1'b0;
    cyc(2);
    chk({7'h00, lat, selo}, 16'h0000);
    final_report;
  end
endmodule // tb
